// [src/tx_clock_loop_select_defs.svh]
// Register map, field positions, reset values and limits of the transmit clock selector
`ifndef TX_CLOCK_LOOP_SELECT_DEFS_SVH
`define TX_CLOCK_LOOP_SELECT_DEFS_SVH

`define AVS_ADDR_W 5
`define RATE_W 24

`define REG_CTRL 5'h00
`define REG_TX_RATE 5'h04
`define REG_RX_RATE 5'h08
`define REG_EXT_FREQ 5'h0c
`define REG_STATUS 5'h10

`define CTRL_SRC_POS 0
`define CTRL_LOOP_POS 2
`define CTRL_MODREF_POS 3
`define CTRL_IFACE_POS 4
`define CTRL_ASYM_POS 6
`define CTRL_LREF_POS 8

`define STAT_SRC_POS 0
`define STAT_SCTLOOP_POS 2
`define STAT_REFSEL_POS 3
`define STAT_BYPASS_POS 4
`define STAT_ASYM_POS 5
`define STAT_FALLBACK_POS 6
`define STAT_FLEGAL_POS 7
`define STAT_EXTTOL_POS 8
`define STAT_RXTOL_POS 9
`define STAT_STEN_POS 10
`define STAT_STSEL_POS 12
`define STAT_PLLSEL_POS 14

`define RST_TX_RATE 24'h00_fa00
`define RST_RX_RATE 24'h00_fa00
`define RST_EXT_FREQ 24'h17_8f40

`define FREQ_HIGH 24'h00_fa00
`define FREQ_MID 24'h00_7d00
`define STEP_8K 24'h00_1f40
`define STEP_600 24'h00_0258
`define TOL_PPM 100
`define PPM_FULL 1000000
`define TOL_SCALE (`PPM_FULL / `TOL_PPM)

`define IN_TT 0
`define IN_TXD 1
`define IN_EXT 2
`define IN_RXC 3
`define IN_RXD 4
`define IN_DDS 5
`define IN_PLL 6
`define IN_COUNT 7

`endif

// [src/tx_clock_loop_select_pkg.sv]
// Types shared by the transmit clock selector modules
package tx_clock_loop_select_pkg;

   typedef enum logic [1:0] {
      TX_SRC_TERR,
      TX_SRC_INT,
      TX_SRC_EXT,
      TX_SRC_LOOP_ASYM
   } tx_src_e;

   typedef enum logic [1:0] {
      IFACE_EIA422,
      IFACE_V35,
      IFACE_G703,
      IFACE_EIA232
   } iface_e;

   typedef enum logic [1:0] {
      LOOP_REF_TT,
      LOOP_REF_EXT,
      LOOP_REF_RX
   } loop_ref_e;

   typedef enum logic [1:0] {
      ST_SEL_DDS,
      ST_SEL_PLL,
      ST_SEL_RX,
      ST_SEL_EXT
   } st_sel_e;

endpackage

// [src/glitch_free_clock_switch.sv]
// Glitch-free selector between sampled clock levels
module glitch_free_clock_switch #(
   parameter int N = 4,
   parameter int SW = 2
) (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic [N-1:0] clocks_i,
   input wire logic [SW-1:0] select_i,
   output logic clock_o,
   output logic [SW-1:0] active_o
);

   typedef struct packed {
      logic [SW-1:0] cur;
      logic out;
   } sw_s;

   sw_s q;
   sw_s next_q;

   always_comb begin
      next_q = q;
      if (select_i != q.cur) begin
         // Old source may only finish its high phase; switch while both are low
         next_q.out = q.out & clocks_i[q.cur];
         if (!q.out && !clocks_i[select_i]) begin
            next_q.cur = select_i;
         end
      end else begin
         next_q.out = clocks_i[q.cur];
      end
   end

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   assign clock_o = q.out;
   assign active_o = q.cur;

endmodule // glitch_free_clock_switch

// [src/tx_clock_loop_select.sv]
// Transmit clock source selection and asymmetrical loop timing with Avalon-MM registers
//
// Function
// - Loop reference: terminal, external or receive clock
// - Receive or external source needs 100 PPM agreement
// - Basic mode: external clock must equal data rate
// - Capture transmit data on terminal transmit clock in terrestrial mode, on send timing otherwise
// - Present receive data on receive timing clock
// - Asymmetric: common clock, differing transmit/receive rates
// - Loop timing turns internal send clock loop
// - External modulator reference moves reference selector
// - Equal rates bypass PLL, disable asymmetric mode
// - Loop timing drives recovered clock on send timing
// - No loop timing in G.703 operation (TX_SRC_LOOP_ASYM still runs there)
//
// The register addresses and the Avalon-MM register port were decided locally.
`include "tx_clock_loop_select_defs.svh"

module tx_clock_loop_select
   import tx_clock_loop_select_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic [`AVS_ADDR_W-1:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input wire logic terminal_tx_clock_i,
   input wire logic tx_data_i,
   input wire logic external_clock_input_i,
   input wire logic rx_recovered_clock_i,
   input wire logic rx_bit_i,
   input wire logic synthesized_clock_path_i,
   input wire logic pll_clock_i,
   output logic send_timing_output_o,
   output logic receive_timing_clock_o,
   output logic rx_data_o,
   output logic tx_bit_o,
   output logic tx_bit_strobe_o,
   output logic pll_ref_clock_o,
   output logic [1:0] pll_ref_select_o,
   output logic pll_bypass_o,
   output logic reference_selector_o
);

   typedef struct packed {
      logic [`IN_COUNT-1:0] s1;
      logic [`IN_COUNT-1:0] s2;
      logic [`IN_COUNT-1:0] prev;
      tx_src_e src;
      logic loop_en;
      logic ref_ext;
      iface_e iface;
      logic asym_en;
      loop_ref_e loop_ref;
      logic [`RATE_W-1:0] tx_rate;
      logic [`RATE_W-1:0] rx_rate;
      logic [`RATE_W-1:0] ext_freq;
      logic ack;
      logic [31:0] rdata;
      logic cap_prev;
      logic tx_bit;
      logic tx_stb;
      logic rx_data;
      logic rt_clk;
      logic st;
   } state_s;

   state_s q;
   state_s next_q;

   // Byte-lane merge of a register write
   function automatic logic [31:0] be_merge(
      input logic [31:0] old_val,
      input logic [31:0] wdata,
      input logic [3:0] be
   );
      logic [31:0] res;
      res = old_val;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            res[i*8 +: 8] = wdata[i*8 +: 8];
         end
      end
      return res;
   endfunction

   // Agreement of two rates within the loop tolerance
   function automatic logic within_tol(
      input logic [`RATE_W-1:0] a,
      input logic [`RATE_W-1:0] b
   );
      logic [`RATE_W-1:0] d;
      d = (a > b) ? a - b : b - a;
      return (40'(d) * 40'(`TOL_SCALE)) <= 40'(b);
   endfunction

   // Frequency step check for a clock input
   function automatic logic freq_legal(input logic [`RATE_W-1:0] f);
      logic ok;
      if (f >= `FREQ_HIGH) begin
         ok = (f % `STEP_8K) == '0;
      end else if (f >= `FREQ_MID) begin
         ok = ((f % `STEP_600) == '0) || ((f % `STEP_8K) == '0);
      end else begin
         ok = (f % `STEP_600) == '0;
      end
      return ok;
   endfunction

   logic [`IN_COUNT-1:0] pins;
   logic [`IN_COUNT-1:0] rise;
   logic [`IN_COUNT-1:0] fall;
   logic req;
   logic g703;
   logic pll_bypass;
   logic asym_active;
   logic ext_tol_ok;
   logic rx_tol_ok;
   logic ext_ok;
   logic loop_eff;
   logic st_en;
   logic fallback;
   tx_src_e eff_src;
   st_sel_e st_sel;
   loop_ref_e pll_sel;
   logic st_sw_clk;
   logic [1:0] st_sw_active;
   logic [1:0] pll_sw_active;
   logic capture_clk;
   logic [31:0] ctrl_word;
   logic [31:0] status_word;
   logic [31:0] rd_value;
   logic [31:0] merged;

   assign pins = {pll_clock_i, synthesized_clock_path_i, rx_bit_i, rx_recovered_clock_i,
                  external_clock_input_i, tx_data_i, terminal_tx_clock_i};
   assign rise = q.s2 & ~q.prev;
   assign fall = ~q.s2 & q.prev;

   assign g703 = (q.iface == IFACE_G703);
   assign pll_bypass = (q.rx_rate == q.tx_rate);
   assign asym_active = q.asym_en & ~pll_bypass;
   assign ext_tol_ok = within_tol(q.ext_freq, q.tx_rate);
   assign rx_tol_ok = within_tol(q.rx_rate, q.tx_rate);
   // Without the option the external clock must run at the data rate
   assign ext_ok = q.asym_en | ext_tol_ok;
   // G.703 has no send timing line, so the loop cannot be closed here
   assign loop_eff = q.loop_en & ~g703 & (q.asym_en | rx_tol_ok);
   assign st_en = ~g703;

   // Effective source and clock routing; illegal requests fall back to internal
   always_comb begin
      eff_src = q.src;
      fallback = 1'b0;
      st_sel = ST_SEL_DDS;
      pll_sel = q.loop_ref;
      case (q.src)
         TX_SRC_TERR: begin
            st_sel = ST_SEL_DDS;
         end
         TX_SRC_INT: begin
            st_sel = loop_eff ? ST_SEL_RX : ST_SEL_DDS;
            fallback = q.loop_en & ~loop_eff;
         end
         TX_SRC_EXT: begin
            pll_sel = LOOP_REF_EXT;
            if (!ext_ok) begin
               eff_src = TX_SRC_INT;
               fallback = 1'b1;
            end else if (asym_active) begin
               st_sel = ST_SEL_PLL;
            end else begin
               st_sel = ST_SEL_EXT;
            end
         end
         TX_SRC_LOOP_ASYM: begin
            if (asym_active) begin
               st_sel = ST_SEL_PLL;
            end else begin
               eff_src = TX_SRC_INT;
               fallback = 1'b1;
            end
         end
         default: begin
            st_sel = ST_SEL_DDS;
         end
      endcase
   end

   glitch_free_clock_switch #(
      .N(4),
      .SW(2)
   ) u_st_switch (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .clocks_i({q.s2[`IN_EXT], q.s2[`IN_RXC], q.s2[`IN_PLL], q.s2[`IN_DDS]}),
      .select_i(st_sel),
      .clock_o(st_sw_clk),
      .active_o(st_sw_active)
   );

   glitch_free_clock_switch #(
      .N(3),
      .SW(2)
   ) u_pll_ref_switch (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .clocks_i({q.s2[`IN_RXC], q.s2[`IN_EXT], q.s2[`IN_TT]}),
      .select_i(pll_sel),
      .clock_o(pll_ref_clock_o),
      .active_o(pll_sw_active)
   );

   // Terminal mode samples on the user clock, others on our own send timing
   assign capture_clk = (eff_src == TX_SRC_TERR) ? q.s2[`IN_TT] : st_sw_clk;

   always_comb begin
      ctrl_word = '0;
      ctrl_word[`CTRL_SRC_POS +: 2] = q.src;
      ctrl_word[`CTRL_LOOP_POS] = q.loop_en;
      ctrl_word[`CTRL_MODREF_POS] = q.ref_ext;
      ctrl_word[`CTRL_IFACE_POS +: 2] = q.iface;
      ctrl_word[`CTRL_ASYM_POS] = q.asym_en;
      ctrl_word[`CTRL_LREF_POS +: 2] = q.loop_ref;
   end

   always_comb begin
      status_word = '0;
      status_word[`STAT_SRC_POS +: 2] = eff_src;
      // Internal send clock reads as loop variant once the loop is closed
      status_word[`STAT_SCTLOOP_POS] = (eff_src == TX_SRC_INT) & loop_eff;
      status_word[`STAT_REFSEL_POS] = q.ref_ext;
      status_word[`STAT_BYPASS_POS] = pll_bypass;
      status_word[`STAT_ASYM_POS] = asym_active;
      status_word[`STAT_FALLBACK_POS] = fallback;
      status_word[`STAT_FLEGAL_POS] = freq_legal(q.ext_freq);
      status_word[`STAT_EXTTOL_POS] = ext_tol_ok;
      status_word[`STAT_RXTOL_POS] = rx_tol_ok;
      status_word[`STAT_STEN_POS] = st_en;
      status_word[`STAT_STSEL_POS +: 2] = st_sw_active;
      status_word[`STAT_PLLSEL_POS +: 2] = pll_sw_active;
   end

   always_comb begin
      case (avs_address_i)
         `REG_CTRL: rd_value = ctrl_word;
         `REG_TX_RATE: rd_value = {8'h00, q.tx_rate};
         `REG_RX_RATE: rd_value = {8'h00, q.rx_rate};
         `REG_EXT_FREQ: rd_value = {8'h00, q.ext_freq};
         `REG_STATUS: rd_value = status_word;
         default: rd_value = '0;
      endcase
   end

   always_comb begin
      case (avs_address_i)
         `REG_CTRL: merged = be_merge(ctrl_word, avs_writedata_i, avs_byteenable_i);
         `REG_TX_RATE: merged = be_merge({8'h00, q.tx_rate}, avs_writedata_i, avs_byteenable_i);
         `REG_RX_RATE: merged = be_merge({8'h00, q.rx_rate}, avs_writedata_i, avs_byteenable_i);
         `REG_EXT_FREQ: merged = be_merge({8'h00, q.ext_freq}, avs_writedata_i,
                                          avs_byteenable_i);
         default: merged = '0;
      endcase
   end

   assign req = avs_read_i | avs_write_i;
   // One wait cycle per access; the answer edge is the one with waitrequest low
   assign avs_waitrequest_o = req & ~q.ack;

   always_comb begin
      next_q = q;
      next_q.s1 = pins;
      next_q.s2 = q.s1;
      next_q.prev = q.s2;
      next_q.ack = req & ~q.ack;
      if (req && !q.ack && avs_read_i) begin
         next_q.rdata = rd_value;
      end
      if (q.ack && avs_write_i) begin
         case (avs_address_i)
            `REG_CTRL: begin
               next_q.src = tx_src_e'(merged[`CTRL_SRC_POS +: 2]);
               next_q.loop_en = merged[`CTRL_LOOP_POS];
               next_q.ref_ext = merged[`CTRL_MODREF_POS];
               next_q.iface = iface_e'(merged[`CTRL_IFACE_POS +: 2]);
               next_q.asym_en = merged[`CTRL_ASYM_POS];
               // Only the three defined references are accepted
               if (merged[`CTRL_LREF_POS +: 2] != 2'h3) begin
                  next_q.loop_ref = loop_ref_e'(merged[`CTRL_LREF_POS +: 2]);
               end
            end
            `REG_TX_RATE: next_q.tx_rate = merged[`RATE_W-1:0];
            `REG_RX_RATE: next_q.rx_rate = merged[`RATE_W-1:0];
            `REG_EXT_FREQ: next_q.ext_freq = merged[`RATE_W-1:0];
            default: begin
            end
         endcase
      end

      next_q.cap_prev = capture_clk;
      next_q.tx_stb = capture_clk & ~q.cap_prev;
      if (capture_clk && !q.cap_prev) begin
         next_q.tx_bit = q.s2[`IN_TXD];
      end

      // Data changes on the falling edge so the user samples on the rising one
      next_q.rt_clk = q.s2[`IN_RXC];
      if (fall[`IN_RXC]) begin
         next_q.rx_data = q.s2[`IN_RXD];
      end
      if (rise[`IN_RXC] && fall[`IN_RXC]) begin
         next_q.rx_data = q.rx_data;
      end

      next_q.st = st_en & st_sw_clk;
   end

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         q <= '0;
         q.tx_rate <= `RST_TX_RATE;
         q.rx_rate <= `RST_RX_RATE;
         q.ext_freq <= `RST_EXT_FREQ;
      end else begin
         q <= next_q;
      end
   end

   assign avs_readdata_o = q.rdata;
   assign send_timing_output_o = q.st;
   assign receive_timing_clock_o = q.rt_clk;
   assign rx_data_o = q.rx_data;
   assign tx_bit_o = q.tx_bit;
   assign tx_bit_strobe_o = q.tx_stb;
   assign pll_ref_select_o = pll_sw_active;
   assign pll_bypass_o = pll_bypass;
   assign reference_selector_o = q.ref_ext;

endmodule // tx_clock_loop_select

// [sim/tx_clock_loop_select_props.sv]
// Port-level checks of the transmit clock selector
module tx_clock_loop_select_props (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic avs_waitrequest_o,
   input wire logic rx_recovered_clock_i,
   input wire logic send_timing_output_o,
   input wire logic receive_timing_clock_o,
   input wire logic rx_data_o,
   input wire logic tx_bit_o,
   input wire logic tx_bit_strobe_o,
   input wire logic pll_ref_clock_o,
   input wire logic [1:0] pll_ref_select_o,
   input wire logic pll_bypass_o,
   input wire logic reference_selector_o
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [1:0] up_cnt;
   logic wr_done;
   assign wr_done = avs_write_i & ~avs_waitrequest_o;
   // Sync stages still hold reset values for three edges
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         up_cnt <= 2'h0;
      end else if (up_cnt != 2'h3) begin
         up_cnt <= up_cnt + 2'h1;
      end
   end
   default clocking @(posedge clk_sys_i);
   endclocking
   default disable iff (rst_i);
   chk_wait_once: assert property ($rose(avs_read_i | avs_write_i)
      |-> avs_waitrequest_o ##1 !avs_waitrequest_o) else $error("bus answer not after one wait");
   chk_bypass_cause: assert property ($changed(pll_bypass_o) |-> $past(wr_done))
      else $error("bypass moved without a write");
   chk_refsel_cause: assert property ($changed(reference_selector_o)
      |-> $past(wr_done) || $past(wr_done, 2)) else $error("reference selector moved alone");
   chk_ref_legal: assert property (pll_ref_select_o != 2'h3)
      else $error("pll reference outside three sources");
   chk_ref_runt: assert property ($fell(pll_ref_clock_o) |=> !pll_ref_clock_o)
      else $error("runt on pll reference");
   chk_st_runt: assert property ($fell(send_timing_output_o) |=> !send_timing_output_o)
      else $error("runt on send timing");
   chk_rt_follow: assert property (up_cnt == 2'h3
      |-> receive_timing_clock_o == $past(rx_recovered_clock_i, 3)) else $error("rt lag wrong");
   chk_rx_edge: assert property ($changed(rx_data_o) |-> $fell(receive_timing_clock_o))
      else $error("rx data moved off rt fall");
   chk_strobe_pulse: assert property (tx_bit_strobe_o |=> !tx_bit_strobe_o)
      else $error("tx strobe too long");
   chk_bit_update: assert property ($changed(tx_bit_o) |-> tx_bit_strobe_o)
      else $error("tx bit moved without strobe");
   cover property (wr_done);
   cover property ($fell(pll_bypass_o));
   cover property (tx_bit_strobe_o);
endmodule // tx_clock_loop_select_props

bind tx_clock_loop_select tx_clock_loop_select_props tx_clock_loop_select_props_inst (.*);

// [sim/user_equipment_model.sv]
// Behavioural terrestrial user equipment: terminal clock and send data
module user_equipment_model (
   input wire logic clk_sys_i,
   input wire logic run_i,
   input wire logic data_i,
   output logic terminal_tx_clock_o,
   output logic tx_data_o
);
   timeunit 1ns;
   timeprecision 100ps;
   logic active = 1'h0;
   initial terminal_tx_clock_o = 1'h0;
   initial tx_data_o = 1'h0;
   // Released line toggles so a stale bit never passes for data
   always @(posedge clk_sys_i) if (!active) tx_data_o <= ~tx_data_o;
   // 8 MHz clock, stands low between frames
   always begin
      wait (run_i === 1'h1);
      active = 1'h1;
      #1.7;
      while (run_i === 1'h1) begin
         terminal_tx_clock_o = 1'h1;
         #62.5;
         terminal_tx_clock_o = 1'h0;
         tx_data_o = data_i;
         #62.5;
      end
      active = 1'h0;
   end
endmodule // user_equipment_model

// [sim/tx_clock_loop_select_tb.sv]
// Self-checking bench for the transmit clock selector
`include "tx_clock_loop_select_defs.svh"
module tx_clock_loop_select_tb
   import tx_clock_loop_select_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_sys_i = 1'h0, rst_i = 1'h1, avs_read_i = 1'h0, avs_write_i = 1'h0;
   logic [`AVS_ADDR_W-1:0] avs_address_i = '0;
   logic [31:0] avs_writedata_i = '0, avs_readdata_o, v, seed = 32'h12fb_e7bd;
   logic [3:0] avs_byteenable_i = 4'hf;
   logic avs_waitrequest_o, terminal_tx_clock_i, tx_data_i, rx_bit_i = 1'h0;
   logic external_clock_input_i = 1'h0, rx_recovered_clock_i = 1'h0;
   logic synthesized_clock_path_i = 1'h0, pll_clock_i = 1'h0;
   logic send_timing_output_o, receive_timing_clock_o, rx_data_o, tx_bit_o, tx_bit_strobe_o;
   logic pll_ref_clock_o, pll_bypass_o, reference_selector_o, run = 1'h0, link_on = 1'h0;
   logic rt_d = 1'h0;
   logic [1:0] pll_ref_select_o;
   logic tx_q[$], rx_q[$];
   logic [63:0] rd_q[$];
   logic [31:0] ext_v[4] = '{32'h0017_8f40, 32'h0000_fa06, 32'h0000_fa07, 32'h0000_f9fa};
   logic [31:0] ext_s[4] = '{32'h0000_00c1, 32'h0000_3102, 32'h0000_0041, 32'h0000_3102};
   int error_cnt = 0, cmp_count = 0, cyc = 0;

   tx_clock_loop_select tx_clock_loop_select_inst (.*);
   user_equipment_model user_equipment_model_inst (.clk_sys_i(clk_sys_i), .run_i(run),
      .data_i(seed[3]), .terminal_tx_clock_o(terminal_tx_clock_i), .tx_data_o(tx_data_i));

   initial forever #4 clk_sys_i = ~clk_sys_i;
   // Offsets keep link edges off system clock edges
   always #40 synthesized_clock_path_i = ~synthesized_clock_path_i;
   always #48 pll_clock_i = ~pll_clock_i;
   initial #3.1 forever #62.5 rx_recovered_clock_i = ~rx_recovered_clock_i;
   initial #5.7 forever #62.5 external_clock_input_i = ~external_clock_input_i;
   always @(posedge rx_recovered_clock_i) rx_bit_i <= seed[7];
   always @(negedge rx_recovered_clock_i) if (link_on) rx_q.push_back(rx_bit_i);
   always @(posedge terminal_tx_clock_i) if (run) tx_q.push_back(tx_data_i);

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   task automatic finish_test();
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic cmp_word(input string n, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic cmp_bit(input string n, input logic e, input logic g);
      cmp_word(n, {31'h0, e}, {31'h0, g});
   endtask

   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
         input logic [3:0] be);
      avs_address_i <= a;
      avs_writedata_i <= d;
      avs_byteenable_i <= be;
      avs_write_i <= w;
      avs_read_i <= ~w;
      // Request stands until waitrequest is seen low at a rising edge
      @(posedge clk_sys_i);
      while (avs_waitrequest_o !== 1'h0) @(posedge clk_sys_i);
      avs_write_i <= 1'h0;
      avs_read_i <= 1'h0;
      @(posedge clk_sys_i);
   endtask

   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      bus(1'h1, a, d, 4'hf);
   endtask

   task automatic rdc(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
      rd_q.push_back({m, e});
      bus(1'h0, a, 32'h0, 4'hf);
   endtask

   task automatic st_rate(input int lo, input int hi);
      int n;
      logic p;
      n = 0;
      repeat (100) @(posedge clk_sys_i);
      p = send_timing_output_o;
      repeat (250) begin
         @(posedge clk_sys_i);
         if (send_timing_output_o && !p) n++;
         p = send_timing_output_o;
      end
      cmp_bit("st_edges", 1'h1, n >= lo && n <= hi);
   endtask

   always @(posedge clk_sys_i) begin
      cyc <= cyc + 1;
      seed <= xs(seed);
      rt_d <= receive_timing_clock_o;
      if (avs_read_i === 1'h1 && avs_waitrequest_o === 1'h0) begin
         cmp_word("readdata", rd_q[0][31:0], avs_readdata_o & rd_q[0][63:32]);
         void'(rd_q.pop_front());
      end
      if (tx_bit_strobe_o === 1'h1 && tx_q.size() > 0) begin
         cmp_bit("tx_bit", tx_q.pop_front(), tx_bit_o);
      end
      if (rt_d === 1'h1 && receive_timing_clock_o === 1'h0 && rx_q.size() > 0) begin
         cmp_bit("rx_data", rx_q.pop_front(), rx_data_o);
      end
      if (cyc == 20000) begin
         error_cnt++;
         finish_test();
      end
   end

   initial begin
      repeat (5) @(posedge clk_sys_i);
      rst_i <= 1'h0;
      link_on <= 1'h1;
      @(posedge clk_sys_i);
      rdc(`REG_CTRL, '1, 32'h0);
      rdc(`REG_TX_RATE, '1, 32'h0000_fa00);
      rdc(`REG_RX_RATE, '1, 32'h0000_fa00);
      rdc(`REG_EXT_FREQ, '1, 32'h0017_8f40);
      rdc(`REG_STATUS, '1, 32'h0000_0690);
      rdc(5'h14, '1, 32'h0);
      for (int i = 0; i < 3; i++) begin
         v = seed;
         wr(`REG_EXT_FREQ, v);
         rdc(`REG_EXT_FREQ, '1, v & 32'h00ff_ffff);
      end
      bus(1'h1, `REG_EXT_FREQ, 32'hffff_ffff, 4'h2);
      rdc(`REG_EXT_FREQ, '1, (v & 32'h00ff_00ff) | 32'h0000_ff00);
      bus(1'h1, 5'h14, v, 4'hf);
      rdc(5'h14, '1, 32'h0);
      wr(`REG_STATUS, '1);
      rdc(`REG_STATUS, 32'h0000_063f, 32'h0000_0610);
      wr(`REG_CTRL, 32'h0000_0008);
      repeat (4) @(posedge clk_sys_i);
      cmp_bit("ref_sel", 1'h1, reference_selector_o);
      rdc(`REG_STATUS, 32'h0000_0008, 32'h0000_0008);
      wr(`REG_CTRL, 32'h0);
      run <= 1'h1;
      repeat (250) @(posedge clk_sys_i);
      run <= 1'h0;
      repeat (40) @(posedge clk_sys_i);
      cmp_word("tx_left", 32'h0, tx_q.size());
      wr(`REG_CTRL, 32'h0000_0005);
      // Clock muxes move only once old and new clock are both low
      repeat (30) @(posedge clk_sys_i);
      rdc(`REG_STATUS, 32'h0000_3007, 32'h0000_2005);
      st_rate(15, 17);
      wr(`REG_CTRL, 32'h0000_0025);
      rdc(`REG_STATUS, 32'h0000_0404, 32'h0);
      st_rate(0, 0);
      cmp_bit("st_level", 1'h0, send_timing_output_o);
      wr(`REG_CTRL, 32'h0000_0002);
      foreach (ext_v[i]) begin
         wr(`REG_EXT_FREQ, ext_v[i]);
         repeat (30) @(posedge clk_sys_i);
         rdc(`REG_STATUS, 32'h0000_31c3, ext_s[i]);
      end
      st_rate(15, 17);
      wr(`REG_RX_RATE, 32'h0000_7d00);
      rdc(`REG_RX_RATE, '1, 32'h0000_7d00);
      cmp_bit("bypass", 1'h0, pll_bypass_o);
      for (int r = 0; r < 4; r++) begin
         wr(`REG_CTRL, 32'h0000_0043 | (r << 8));
         repeat (30) @(posedge clk_sys_i);
         rdc(`REG_STATUS, 32'h0000_f023, ((r == 3 ? 2 : r) << 14) | 32'h1023);
         cmp_word("pll_ref", r == 3 ? 2 : r, pll_ref_select_o);
      end
      wr(`REG_RX_RATE, 32'h0000_fa00);
      cmp_bit("bypass", 1'h1, pll_bypass_o);
      rdc(`REG_STATUS, 32'h0000_0070, 32'h0000_0050);
      finish_test();
   end
endmodule // tx_clock_loop_select_tb
